/* hw/tx_command_a_decoder.sv */
// Decoder of transmit command A and payload word filter
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "tx_cmd_regs.svh"
module tx_command_a_decoder
  import tx_cmd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        in_valid,
  input  wire logic [31:0] in_data,
  output logic             in_ready,
  output logic             out_valid,
  output logic [31:0]      out_data,
  output logic [3:0]       out_be,
  output logic             tx_buffer_done_flag,
  output logic             tx_error_flag,
  output logic             irq,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  dec_regs_s r_r;
  dec_regs_s r_nxt;
  logic      done_q;
  logic      err_q;
  logic      status_clr_wr;
  logic      take;

  assign status_clr_wr = reg_wr && (reg_addr == `REG_STATUS_OFS);
  assign take          = in_valid && r_r.in_ready;

  // ----------------------------------------
  // Sticky event flags
  // ----------------------------------------
  sticky_flag u_done
  (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (r_r.done_pulse),
    .clr   (status_clr_wr && reg_wdata[`BIT_DONE]),
    .q     (done_q)
  );

  sticky_flag u_err
  (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (r_r.err_pulse),
    .clr   (status_clr_wr && reg_wdata[`BIT_ERR]),
    .q     (err_q)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [11:0] bytes_v;
    logic [11:0] dw_v;
    logic [11:0] tw_v;
    logic [3:0]  be_v;
    logic [2:0]  skip_v;
    logic [1:0]  align_v;
    bytes_v = '0;
    dw_v    = '0;
    tw_v    = '0;
    be_v    = 4'hf;
    skip_v  = 3'h0;
    align_v = 2'h0;
    r_nxt   = r_r;

    r_nxt.in_ready   = 1'b1;
    r_nxt.out_valid  = 1'b0;
    r_nxt.done_pulse = 1'b0;
    r_nxt.err_pulse  = 1'b0;

    case (r_r.st)
      ST_CMD_A:
      begin
        if (take)
        begin
          align_v = in_data[`CMD_ALIGN_HI:`CMD_ALIGN_LO];                  // [RL4]
          bytes_v = {7'h00, in_data[`CMD_OFS_HI:`CMD_OFS_LO]}              // [RL7]
                  + {1'b0, in_data[`CMD_SIZE_HI:`CMD_SIZE_LO]};
          dw_v    = (bytes_v + 12'h003) >> 2;
          case (align_v)
            `ALIGN_16: tw_v = (dw_v + `ROUND_16) & ~`ROUND_16;              // [RL4]
            `ALIGN_32: tw_v = (dw_v + `ROUND_32) & ~`ROUND_32;              // [RL4]
            default:   tw_v = dw_v;
          endcase
          r_nxt.ioc         = in_data[`CMD_IOC_BIT];                        // [RL1]
          r_nxt.ofs         = in_data[`CMD_OFS_HI:`CMD_OFS_LO];
          r_nxt.align       = align_v;
          r_nxt.bytes       = bytes_v;
          r_nxt.data_words  = dw_v;
          r_nxt.total_words = tw_v;
          r_nxt.drop        = (align_v == `ALIGN_RSVD);                     // [RL10]
          r_nxt.err_pulse   = (align_v == `ALIGN_RSVD);                     // [RL10]
          r_nxt.wcnt        = '0;
          r_nxt.st          = ST_CMD_B;                                     // [RL9]
        end
      end
      ST_CMD_B:
      begin
        if (take)
        begin
          if (r_r.total_words == 12'h000)
          begin
            r_nxt.done_pulse = r_r.ioc && !r_r.drop;                        // [RL1][RL10]
            r_nxt.st         = ST_CMD_A;
          end
          else
          begin
            r_nxt.st = ST_DATA;
          end
        end
      end
      ST_DATA:
      begin
        if (take)
        begin
          skip_v = r_r.ofs[4:2];
          if (r_r.wcnt == {9'h000, skip_v})
          begin
            be_v = be_v & (4'hf << r_r.ofs[1:0]);                           // [RL8]
          end
          if ((r_r.wcnt == r_r.data_words - 12'h001) && (r_r.bytes[1:0] != 2'h0))
          begin
            be_v = be_v & (4'hf >> (3'h4 - {1'b0, r_r.bytes[1:0]}));
          end
          // Leading skipped words and trailing filler are swallowed
          r_nxt.out_valid = !r_r.drop
                          && (r_r.wcnt >= {9'h000, skip_v})                 // [RL8]
                          && (r_r.wcnt < r_r.data_words);                   // [RL6]
          r_nxt.out_data  = in_data;
          r_nxt.out_be    = be_v;
          r_nxt.wcnt      = r_r.wcnt + 12'h001;
          if (r_r.wcnt == r_r.total_words - 12'h001)
          begin
            r_nxt.done_pulse = r_r.ioc && !r_r.drop;                        // [RL1]
            r_nxt.st         = ST_CMD_A;
          end
        end
      end
      default:
      begin
        r_nxt.st = ST_CMD_A;
      end
    endcase

    // Register bus
    if (reg_wr && (reg_addr == `REG_MASK_OFS))
    begin
      r_nxt.mask = reg_wdata[1:0];
    end
    r_nxt.irq = |({err_q, done_q} & r_r.mask);                              // [RL2]
    r_nxt.rd_data = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        `REG_STATUS_OFS: r_nxt.rd_data = {30'h0, err_q, done_q};
        `REG_MASK_OFS:   r_nxt.rd_data = {30'h0, r_r.mask};
        `REG_STATE_OFS:  r_nxt.rd_data = {r_r.wcnt, 3'h0, r_r.ofs, 4'h0, r_r.align,
                                          r_r.drop, r_r.ioc, 2'h0, r_r.st};
        default:         r_nxt.rd_data = '0;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_r <= '0;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign in_ready            = r_r.in_ready;
  assign out_valid           = r_r.out_valid;
  assign out_data            = r_r.out_data;
  assign out_be              = r_r.out_be;
  assign tx_buffer_done_flag = done_q;
  assign tx_error_flag       = err_q;
  assign irq                 = r_r.irq;
  assign reg_rdata           = r_r.rd_data;

endmodule

/* hw/tx_cmd_regs.svh */
// Register offsets, field positions, reset values and counts of the command decoder
// Overview of operation
// (RL1) Command bit 31 set: raise buffer-done flag once the whole buffer has been taken.
// (RL2) Buffer-done flag reaches the interrupt output only when software unmasks it.
// (RL3) Host writes zero to command bits 30:26 and 23:21.
// (RL4) Bits 25:24 select end alignment: 4, 16, 32 bytes, code 11 reserved.
// (RL5) Host appends filler DWORDs so the buffer ends on the alignment boundary.
// (RL6) Filler DWORDs are swallowed, never passed on as payload.
// (RL7) Bits 20:16 give byte offset 0 to 31 of the first valid byte.
// (RL8) Offset bits 1:0 pick the first byte lane; bits 4:2 skip whole DWORDs.
// (RL9) Host writes command A, then command B, then the payload.
// (RL10) Reserved alignment code raises the transmit error flag; buffer is dropped.
`ifndef TX_CMD_REGS_SVH
`define TX_CMD_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_STATUS_OFS    8'h00
`define REG_MASK_OFS      8'h04
`define REG_STATE_OFS     8'h08

// ----------------------------------------
// Status and mask bit positions
// ----------------------------------------
`define BIT_DONE          0
`define BIT_ERR           1
`define MASK_RST          2'h0

// ----------------------------------------
// Command A fields
// ----------------------------------------
`define CMD_IOC_BIT       31
`define CMD_ALIGN_HI      25
`define CMD_ALIGN_LO      24
`define CMD_OFS_HI        20
`define CMD_OFS_LO        16
`define CMD_SIZE_HI       10
`define CMD_SIZE_LO       0

// ----------------------------------------
// Alignment codes and DWORD groupings
// ----------------------------------------
`define ALIGN_4           2'h0
`define ALIGN_16          2'h1
`define ALIGN_32          2'h2
`define ALIGN_RSVD        2'h3
`define ROUND_16          12'h003
`define ROUND_32          12'h007

`endif

/* hw/tx_cmd_pkg.sv */
// Types of the transmit command decoder
package tx_cmd_pkg;

  typedef enum logic [1:0]
  {
    ST_CMD_A = 2'b00,
    ST_CMD_B = 2'b01,
    ST_DATA  = 2'b10
  } dec_state_e;

  typedef struct packed
  {
    dec_state_e  st;
    logic        ioc;
    logic        drop;
    logic [4:0]  ofs;
    logic [1:0]  align;
    logic [11:0] bytes;
    logic [11:0] data_words;
    logic [11:0] total_words;
    logic [11:0] wcnt;
    logic        out_valid;
    logic [31:0] out_data;
    logic [3:0]  out_be;
    logic        in_ready;
    logic        done_pulse;
    logic        err_pulse;
    logic [1:0]  mask;
    logic        irq;
    logic [31:0] rd_data;
  } dec_regs_s;

  typedef struct packed
  {
    logic q;
  } flag_regs_s;

endpackage

/* hw/sticky_flag.sv */
// Sticky event flag, cleared by writing one, set wins over clear
`timescale 1ns/1ns
module sticky_flag
  import tx_cmd_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);

  flag_regs_s r_r;
  flag_regs_s r_nxt;

  always_comb
  begin
    r_nxt = r_r;
    if (set)
    begin
      r_nxt.q = 1'b1;
    end
    else if (clr)
    begin
      r_nxt.q = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_r <= '0;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.q;

endmodule

/* dv/tx_cmd_monitor.sv */
// Port assertions of the command decoder
`timescale 1ns/1ns
module tx_cmd_monitor
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire logic [31:0] in_data,
  input wire logic        out_valid,
  input wire logic [3:0]  out_be,
  input wire logic        tx_buffer_done_flag,
  input wire logic        tx_error_flag,
  input wire logic        irq,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_done_cause: assert property ($rose(tx_buffer_done_flag) |-> $past(in_valid && in_ready, 2))
    else $error("done without last word");
  a_done_clear: assert property ($fell(tx_buffer_done_flag) |->
    $past(reg_wr && reg_addr == 8'h00 && reg_wdata[0]))
    else $error("done lost");
  a_irq_cause: assert property (irq |-> $past(tx_buffer_done_flag || tx_error_flag))
    else $error("irq without flag");
  a_err_cause: assert property ($rose(tx_error_flag) |-> $past(in_valid && in_data[25:24] == 2'h3, 2))
    else $error("error without code");
  a_out_cause: assert property (out_valid |-> $past(in_valid && in_ready))
    else $error("output without input");
  a_be_shape: assert property (out_valid |->
    out_be inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'hc, 4'he, 4'hf})
    else $error("bad lanes");
  a_be_live: assert property (out_valid |-> out_be != 4'h0)
    else $error("empty lanes");
  c_done: cover property ($rose(tx_buffer_done_flag));
  c_err: cover property ($rose(tx_error_flag));
  c_irq: cover property ($rose(irq));
endmodule

/* dv/host_writer.sv */
// Host model writing words into the transmit stream
`timescale 1ns/1ns
module host_writer
(
  input wire logic    clk,
  input wire logic    rst_n,
  input wire logic    in_ready,
  output logic        in_valid,
  output logic [31:0] in_data
);
  initial
  begin
    in_valid = 0;
    in_data = 0;
  end
  task send(logic [31:0] w, int gap);
    if (gap)
    begin
      rel();
      repeat (gap) @(posedge clk);
    end
    in_valid <= 1;
    in_data <= w;
    do
      @(posedge clk);
    while (in_ready !== 1'b1 || !rst_n);
  endtask
  // Idle bus shows inverse word
  task rel();
    in_valid <= 0;
    in_data <= ~in_data;
  endtask
endmodule

/* dv/test_tx_command_a_decoder.sv */
// Self-checking bench of the command decoder
`timescale 1ns/1ns
module test_tx_command_a_decoder;
  import tx_cmd_pkg::*;
  logic        clk = 0;
  logic        rst_n = 0;
  logic        in_valid;
  logic        in_ready;
  logic        out_valid;
  logic        dn;
  logic        er;
  logic        irq;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic [3:0]  out_be;
  logic [7:0]  reg_addr = 0;
  logic [31:0] in_data;
  logic [31:0] out_data;
  logic [31:0] reg_wdata = 0;
  logic [31:0] reg_rdata;
  logic [31:0] rdv;
  logic [31:0] m;
  logic [35:0] exp_q[$];
  int          err_total = 0;
  int          n_compared = 0;
  always #2 clk = ~clk;
  host_writer host (.clk(clk), .rst_n(rst_n), .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data));
  tx_command_a_decoder dut (.clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_be(out_be), .tx_buffer_done_flag(dn), .tx_error_flag(er),
    .irq(irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task chk(logic [35:0] g, logic [35:0] e);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task rw(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
    reg_rd <= 0;
    @(negedge clk);
    rdv = reg_rdata;
  endtask
  task buf_run(logic ioc, logic [1:0] al, logic [4:0] ofs, logic [10:0] sz, int gp);
    int          b;
    int          dw;
    int          tw;
    logic [31:0] w;
    logic [3:0]  be;
    b = ofs + sz;
    dw = (b + 3) / 4;
    tw = al == 1 ? (dw + 3) / 4 * 4 : al == 2 ? (dw + 7) / 8 * 8 : dw;
    @(posedge clk);
    host.send({ioc, 5'h00, al, 3'h0, ofs, 5'h00, sz}, gp);
    host.send($urandom, 0);
    for (int i = 0; i < tw; i++)
    begin
      w = $urandom;
      be = i == ofs[4:2] ? 4'hf << ofs[1:0] : 4'hf;
      if (i == dw - 1 && b[1:0] != 0)
        be &= 4'hf >> (4 - b[1:0]);
      if (i >= ofs[4:2] && i < dw && al != 3)
        exp_q.push_back({be, w});
      host.send(w, $urandom % (gp + 1));
    end
    host.rel();
    repeat (6) @(posedge clk);
    rw(0, 8'h00, 0);
    chk(rdv, {al == 3, ioc && al != 3});
    chk({er, dn}, {al == 3, ioc && al != 3});
    chk(irq, |({al == 3, ioc && al != 3} & m[1:0]));
    rw(0, 8'h08, 0);
    chk(rdv, {tw[11:0], 3'h0, ofs, 4'h0, al, al == 2'h3, ioc, 4'h0});
    rw(1, 8'h00, 32'h3);
  endtask
  always @(negedge clk)
    if (out_valid === 1'b1)
      chk({out_be, out_data}, exp_q.size() ? exp_q.pop_front() : ~{out_be, out_data});
  initial
  begin
    void'($urandom(32'hb8be));
    repeat (12) @(posedge clk);
    chk({in_ready, out_valid, dn, er, irq}, 0);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    chk(in_ready, 1);
    m = 1;
    rw(1, 8'h04, m);
    rw(0, 8'h04, 0);
    chk(rdv, 1);
    rw(0, 8'h40, 0);
    chk(rdv, 0);
    buf_run(1, 0, 1, 3, 0);
    $display("test basic done");
    for (int t = 0; t < 24; t++)
    begin
      m = $urandom;
      rw(1, 8'h04, m);
      buf_run(t < 4 || $urandom % 2, t < 4 ? t : $urandom, $urandom, 1 + $urandom % 40,
              t % 3);
      $display("test %0d done", t);
    end
    chk(exp_q.size(), 0);
    stop_test();
  end
  initial
  begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule
bind tx_command_a_decoder tx_cmd_monitor mon (.clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_ready(in_ready),
  .in_data(in_data), .out_valid(out_valid), .out_be(out_be), .tx_buffer_done_flag(tx_buffer_done_flag),
  .tx_error_flag(tx_error_flag), .irq(irq), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
